//--- ifs_flags.sv
// How it works
// R1: a flag reads 1 after its source has requested an interrupt and 0 otherwise.
// R2: every implemented flag is software read/write and clears to 0 at reset.
// R3: unimplemented flag positions read 0 and ignore writes.
// R4: pending_0 holds compare 1 at bit 2, capture 1 at bit 1, external 0 at bit 0.
// R5: pending_1 bits 15..8 hold uart2 tx/rx, ext 2, timer 5/4, compare 4/3, dma 2.
// R6: pending_1 bits 7,6,4..0 hold capture 8/7, ext 1, pin change, comparator, i2c; bit 5 unused.
// R7: pending_2 holds dma 4, parallel port, dma 3, can event/rx, spi2 event/error.
// R8: pending_3 holds pwm1 fault, rtc, dma 5, quad decoder 1, pwm1 event.
// R9: pending_4 bits 15,14,11,10,9 hold audio left/right, quad 2, pwm2 fault/event.
// R10: pending_4 bits 6..1 hold can tx, dma 7/6, checksum, uart2/uart1 error.
// R11: without the can controller its three flags stay 0.
// R12: without the audio dac its two flags stay 0.
// R13: a flag reaches the cpu only while its enable bit is 1; enable never alters the flag.
// R14: external pins set their flag on a falling edge if polarity is 1, rising edge if 0.
// R15: a hardware set wins over a software clear in the same cycle.
//
// The implementer's own choices: the placing of the registers and strobed register access.
module ifs_flags
  import ifs_pkg::*;
#(
  parameter bit HAS_CAN   = 1'b1,
  parameter bit HAS_AUDIO = 1'b1
) (
  input  wire logic              mclk,         // system clock
  input  wire logic              reset,        // synchronous, active high
  input  wire logic [IFS_AW-1:0] addr,         // register index
  input  wire logic [15:0]       wdata,        // write data
  input  wire logic              wr,           // write strobe
  input  wire logic              rd,           // read strobe
  output logic      [15:0]       rdata,        // read data, cycle after rd
  input  wire logic [15:0]       src_req_0,    // source pulses, pending_0 layout
  input  wire logic [15:0]       src_req_1,    // source pulses, pending_1 layout
  input  wire logic [15:0]       src_req_2,    // source pulses, pending_2 layout
  input  wire logic [15:0]       src_req_3,    // source pulses, pending_3 layout
  input  wire logic [15:0]       src_req_4,    // source pulses, pending_4 layout
  input  wire logic [2:0]        ext_pin,      // external interrupt pins, async
  output logic      [15:0]       cpu_req_0,    // flag and enable, register 0
  output logic      [15:0]       cpu_req_1,    // flag and enable, register 1
  output logic      [15:0]       cpu_req_2,    // flag and enable, register 2
  output logic      [15:0]       cpu_req_3,    // flag and enable, register 3
  output logic      [15:0]       cpu_req_4     // flag and enable, register 4
);

  // ****************************************
  // implemented masks per variant
  // ****************************************
  localparam logic [15:0] IMPL_2 = HAS_CAN ? MASK_PENDING_2 : (MASK_PENDING_2 & ~MASK_CAN_2);
  localparam logic [15:0] IMPL_4 = MASK_PENDING_4
                                   & ~(HAS_CAN   ? 16'h0000 : MASK_CAN_4)
                                   & ~(HAS_AUDIO ? 16'h0000 : MASK_AUDIO_4);

  logic [15:0] impl [5];
  assign impl[0] = MASK_PENDING_0;  // R4
  assign impl[1] = MASK_PENDING_1;  // R5 R6
  assign impl[2] = IMPL_2;          // R7 R11
  assign impl[3] = MASK_PENDING_3;  // R8
  assign impl[4] = IMPL_4;          // R9 R10 R11 R12

  // next flag value: write first, then hardware sets on top
  function automatic logic [15:0] flag_next(input logic [15:0] cur, input logic [15:0] set,
                                            input logic we, input logic [15:0] wd,
                                            input logic [15:0] msk);
    logic [15:0] base;
    base = we ? wd : cur;
    return (base | set) & msk;
  endfunction

  // ****************************************
  // external pin synchroniser and edges
  // ****************************************
  logic [2:0]  pin_meta_reg;
  logic [2:0]  pin_sync_reg;
  logic [2:0]  pin_last_reg;
  logic [2:0]  ext_edge;
  logic [15:0] polarity_reg;

  always_ff @(posedge mclk) begin
    if (reset) begin
      pin_meta_reg <= 3'h0;
      pin_sync_reg <= 3'h0;
      pin_last_reg <= 3'h0;
    end else begin
      pin_meta_reg <= ext_pin;
      pin_sync_reg <= pin_meta_reg;
      pin_last_reg <= pin_sync_reg;
    end
  end

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      ext_edge[i] = polarity_reg[i] ? (pin_last_reg[i] & ~pin_sync_reg[i])  // R14
                                    : (~pin_last_reg[i] & pin_sync_reg[i]); // R14
    end
  end

  // ****************************************
  // hardware set vectors
  // ****************************************
  logic [15:0] hw_set [5];
  always_comb begin
    hw_set[0] = src_req_0;
    hw_set[1] = src_req_1;
    hw_set[2] = src_req_2;
    hw_set[3] = src_req_3;
    hw_set[4] = src_req_4;
    hw_set[0][BIT_EXT0] = ext_edge[0];  // R14
    hw_set[1][BIT_EXT1] = ext_edge[1];  // R14
    hw_set[1][BIT_EXT2] = ext_edge[2];  // R14
  end

  // ****************************************
  // flag and enable registers
  // ****************************************
  logic [15:0] pending_reg [5];
  logic [15:0] enable_reg  [5];

  always_ff @(posedge mclk) begin
    for (int r = 0; r < 5; r++) begin
      if (reset) begin
        pending_reg[r] <= RST_PENDING;  // R2
      end else begin
        pending_reg[r] <= flag_next(pending_reg[r], hw_set[r],
                                    wr && (addr == ADDR_PENDING_0 + IFS_AW'(r)),
                                    wdata, impl[r]);  // R1 R2 R3 R15
      end
    end
  end

  always_ff @(posedge mclk) begin
    for (int r = 0; r < 5; r++) begin
      if (reset) begin
        enable_reg[r] <= RST_ENABLE;
      end else if (wr && (addr == ADDR_ENABLE_0 + IFS_AW'(r))) begin
        enable_reg[r] <= wdata & impl[r];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      polarity_reg <= RST_POLARITY;
    end else if (wr && (addr == ADDR_POLARITY)) begin
      polarity_reg <= wdata & MASK_POLARITY;
    end
  end

  // ****************************************
  // requests to the cpu
  // ****************************************
  always_ff @(posedge mclk) begin
    if (reset) begin
      cpu_req_0 <= 16'h0000;
      cpu_req_1 <= 16'h0000;
      cpu_req_2 <= 16'h0000;
      cpu_req_3 <= 16'h0000;
      cpu_req_4 <= 16'h0000;
    end else begin
      cpu_req_0 <= pending_reg[0] & enable_reg[0];  // R13
      cpu_req_1 <= pending_reg[1] & enable_reg[1];  // R13
      cpu_req_2 <= pending_reg[2] & enable_reg[2];  // R13
      cpu_req_3 <= pending_reg[3] & enable_reg[3];  // R13
      cpu_req_4 <= pending_reg[4] & enable_reg[4];  // R13
    end
  end

  // ****************************************
  // read port
  // ****************************************
  logic [15:0] rdata_next;
  always_comb begin
    rdata_next = 16'h0000;
    if (rd) begin
      if (addr <= ADDR_PENDING_4) begin
        rdata_next = pending_reg[addr[2:0]];
      end else if (addr <= ADDR_ENABLE_4) begin
        rdata_next = enable_reg[3'(addr - ADDR_ENABLE_0)];
      end else if (addr == ADDR_POLARITY) begin
        rdata_next = polarity_reg;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      rdata <= 16'h0000;
    end else begin
      rdata <= rdata_next;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_unimpl_zero: assert property (@(posedge mclk) disable iff (reset)  // R3
    (pending_reg[3] & ~MASK_PENDING_3) == 16'h0000 && (pending_reg[0] & ~MASK_PENDING_0) == 16'h0000)
    else $error("unimplemented flag bit set");
  a_set_wins: assert property (@(posedge mclk) disable iff (reset)  // R15
    src_req_1[15] && wr && addr == ADDR_PENDING_1 |=> pending_reg[1][15])
    else $error("hardware set lost to clear");
  a_flag_sets: assert property (@(posedge mclk) disable iff (reset)  // R1
    src_req_3[14] |=> pending_reg[3][14])
    else $error("flag not set by source");
  a_write_takes: assert property (@(posedge mclk) disable iff (reset)  // R2
    wr && addr == ADDR_PENDING_0 && src_req_0 == 16'h0000 && !ext_edge[0]
    |=> pending_reg[0] == ($past(wdata) & MASK_PENDING_0))
    else $error("flag write not stored");
  a_can_off: assert property (@(posedge mclk) disable iff (reset)  // R11
    !HAS_CAN |-> pending_reg[2][3:2] == 2'b00 && !pending_reg[4][6])
    else $error("can flag set without can");
  a_audio_off: assert property (@(posedge mclk) disable iff (reset)  // R12
    !HAS_AUDIO |-> pending_reg[4][15:14] == 2'b00)
    else $error("audio flag set without dac");
  sequence s_pin_fall0;
    pin_sync_reg[0] ##1 !pin_sync_reg[0] && polarity_reg[0];
  endsequence
  a_ext_edge: assert property (@(posedge mclk) disable iff (reset)  // R14
    s_pin_fall0 ##0 !(wr && addr == ADDR_POLARITY) |=> pending_reg[0][BIT_EXT0] ##1 1'b1)
    else $error("falling edge not flagged");
  a_req_gate: assert property (@(posedge mclk) disable iff (reset)  // R13
    ##1 cpu_req_2 == ($past(pending_reg[2]) & $past(enable_reg[2])))
    else $error("cpu request not gated by enable");
  a_read_data: assert property (@(posedge mclk) disable iff (reset)  // R1
    rd && addr == ADDR_PENDING_1 |=> rdata == $past(pending_reg[1]))
    else $error("read data wrong");
  a_set_wins3: assert property (@(posedge mclk) disable iff (reset)  // R15
    src_req_3[9] && wr && addr == ADDR_PENDING_3 |=> pending_reg[3][9])
    else $error("hardware set lost to clear");
  a_write_takes3: assert property (@(posedge mclk) disable iff (reset)  // R2
    wr && addr == ADDR_PENDING_3 && src_req_3 == 16'h0000
    |=> pending_reg[3] == ($past(wdata) & MASK_PENDING_3))
    else $error("flag write not stored");

  // ****************************************
  // unimplemented bits, pending 1, 2 and 4, enable 0 and 3, polarity
  // ****************************************
  a_unimpl_zero1: assert property (@(posedge mclk) disable iff (reset)  // R6
    (pending_reg[1] & ~MASK_PENDING_1) == 16'h0000)
    else $error("unimplemented flag bit set");
  a_unimpl_zero2: assert property (@(posedge mclk) disable iff (reset)  // R7 R11
    (pending_reg[2] & ~IMPL_2) == 16'h0000)
    else $error("unimplemented flag bit set");
  a_unimpl_zero4: assert property (@(posedge mclk) disable iff (reset)  // R10 R12
    (pending_reg[4] & ~IMPL_4) == 16'h0000)
    else $error("unimplemented flag bit set");
  a_en_unimpl: assert property (@(posedge mclk) disable iff (reset)  // R13
    (enable_reg[0] & ~MASK_PENDING_0) == 16'h0000 && (enable_reg[3] & ~MASK_PENDING_3) == 16'h0000)
    else $error("unimplemented enable bit set");
  a_pol_unimpl: assert property (@(posedge mclk) disable iff (reset)  // R14
    (polarity_reg & ~MASK_POLARITY) == 16'h0000)
    else $error("unimplemented polarity bit set");

  // ****************************************
  // source to flag, every register
  // ****************************************
  a_flag_sets0: assert property (@(posedge mclk) disable iff (reset)  // R4
    src_req_0[2] |=> pending_reg[0][2])
    else $error("compare 1 flag not set");
  a_flag_sets1h: assert property (@(posedge mclk) disable iff (reset)  // R5
    src_req_1[15] |=> pending_reg[1][15])
    else $error("uart2 tx flag not set");
  a_flag_sets1l: assert property (@(posedge mclk) disable iff (reset)  // R6
    src_req_1[7] |=> pending_reg[1][7])
    else $error("capture 8 flag not set");
  a_flag_sets2: assert property (@(posedge mclk) disable iff (reset)  // R7
    src_req_2[14] |=> pending_reg[2][14])
    else $error("dma 4 flag not set");
  a_flag_sets3: assert property (@(posedge mclk) disable iff (reset)  // R8
    src_req_3[15] |=> pending_reg[3][15])
    else $error("pwm1 fault flag not set");
  a_flag_sets4h: assert property (@(posedge mclk) disable iff (reset)  // R9
    src_req_4[11] |=> pending_reg[4][11])
    else $error("quad decoder 2 flag not set");
  a_flag_sets4l: assert property (@(posedge mclk) disable iff (reset)  // R10
    src_req_4[1] |=> pending_reg[4][1])
    else $error("uart1 error flag not set");
  a_flag_holds: assert property (@(posedge mclk) disable iff (reset)  // R1
    !(wr && addr == ADDR_PENDING_2) && src_req_2 == 16'h0000 |=> pending_reg[2] == $past(pending_reg[2]))
    else $error("flag changed with no cause");
  a_reset_clear: assert property (@(posedge mclk) reset |=>  // R2
    pending_reg[0] == RST_PENDING && pending_reg[1] == RST_PENDING
    && pending_reg[2] == RST_PENDING && pending_reg[3] == RST_PENDING
    && pending_reg[4] == RST_PENDING && rdata == 16'h0000)
    else $error("flags not cleared by reset");

  // ****************************************
  // read port, every register
  // ****************************************
  a_read_p0: assert property (@(posedge mclk) disable iff (reset)  // R1
    rd && addr == ADDR_PENDING_0 |=> rdata == $past(pending_reg[0]))
    else $error("read data wrong");
  a_read_p2: assert property (@(posedge mclk) disable iff (reset)  // R1
    rd && addr == ADDR_PENDING_2 |=> rdata == $past(pending_reg[2]))
    else $error("read data wrong");
  a_read_p3: assert property (@(posedge mclk) disable iff (reset)  // R1
    rd && addr == ADDR_PENDING_3 |=> rdata == $past(pending_reg[3]))
    else $error("read data wrong");
  a_read_p4: assert property (@(posedge mclk) disable iff (reset)  // R1
    rd && addr == ADDR_PENDING_4 |=> rdata == $past(pending_reg[4]))
    else $error("read data wrong");
  a_read_en0: assert property (@(posedge mclk) disable iff (reset)  // R13
    rd && addr == ADDR_ENABLE_0 |=> rdata == $past(enable_reg[0]))
    else $error("enable read wrong");
  a_read_en1: assert property (@(posedge mclk) disable iff (reset)  // R13
    rd && addr == ADDR_ENABLE_1 |=> rdata == $past(enable_reg[1]))
    else $error("enable read wrong");
  a_read_en2: assert property (@(posedge mclk) disable iff (reset)  // R13
    rd && addr == ADDR_ENABLE_2 |=> rdata == $past(enable_reg[2]))
    else $error("enable read wrong");
  a_read_en3: assert property (@(posedge mclk) disable iff (reset)  // R13
    rd && addr == ADDR_ENABLE_3 |=> rdata == $past(enable_reg[3]))
    else $error("enable read wrong");
  a_read_en4: assert property (@(posedge mclk) disable iff (reset)  // R13
    rd && addr == ADDR_ENABLE_4 |=> rdata == $past(enable_reg[4]))
    else $error("enable read wrong");
  a_read_pol: assert property (@(posedge mclk) disable iff (reset)  // R14
    rd && addr == ADDR_POLARITY |=> rdata == $past(polarity_reg))
    else $error("polarity read wrong");
  a_read_unmapped: assert property (@(posedge mclk) disable iff (reset)  // R3
    rd && addr > ADDR_POLARITY |=> rdata == 16'h0000)
    else $error("unmapped read not zero");

  // ****************************************
  // requests to the cpu, every register
  // ****************************************
  a_req_gate0: assert property (@(posedge mclk) disable iff (reset)  // R13
    ##1 cpu_req_0 == ($past(pending_reg[0]) & $past(enable_reg[0])))
    else $error("cpu request not gated by enable");
  a_req_gate1: assert property (@(posedge mclk) disable iff (reset)  // R13
    ##1 cpu_req_1 == ($past(pending_reg[1]) & $past(enable_reg[1])))
    else $error("cpu request not gated by enable");
  a_req_gate3: assert property (@(posedge mclk) disable iff (reset)  // R13
    ##1 cpu_req_3 == ($past(pending_reg[3]) & $past(enable_reg[3])))
    else $error("cpu request not gated by enable");
  a_req_gate4: assert property (@(posedge mclk) disable iff (reset)  // R13
    ##1 cpu_req_4 == ($past(pending_reg[4]) & $past(enable_reg[4])))
    else $error("cpu request not gated by enable");

  // ****************************************
  // rising edge, pin 1
  // ****************************************
  sequence s_pin_rise1;
    !pin_sync_reg[1] ##1 pin_sync_reg[1] && !polarity_reg[1];
  endsequence
  a_ext_rise: assert property (@(posedge mclk) disable iff (reset)  // R14
    s_pin_rise1 |=> pending_reg[1][BIT_EXT1])
    else $error("rising edge not flagged");

endmodule // ifs_flags

//--- ifs_pkg.sv
package ifs_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam int          IFS_AW          = 4;
  localparam logic [3:0]  ADDR_PENDING_0  = 4'h0;
  localparam logic [3:0]  ADDR_PENDING_1  = 4'h1;
  localparam logic [3:0]  ADDR_PENDING_2  = 4'h2;
  localparam logic [3:0]  ADDR_PENDING_3  = 4'h3;
  localparam logic [3:0]  ADDR_PENDING_4  = 4'h4;
  localparam logic [3:0]  ADDR_ENABLE_0   = 4'h5;
  localparam logic [3:0]  ADDR_ENABLE_1   = 4'h6;
  localparam logic [3:0]  ADDR_ENABLE_2   = 4'h7;
  localparam logic [3:0]  ADDR_ENABLE_3   = 4'h8;
  localparam logic [3:0]  ADDR_ENABLE_4   = 4'h9;
  localparam logic [3:0]  ADDR_POLARITY   = 4'hA;

  // ****************************************
  // implemented bit masks
  // ****************************************
  localparam logic [15:0] MASK_PENDING_0  = 16'h0007;
  localparam logic [15:0] MASK_PENDING_1  = 16'hFFDF;
  localparam logic [15:0] MASK_PENDING_2  = 16'h601F;
  localparam logic [15:0] MASK_PENDING_3  = 16'hE600;
  localparam logic [15:0] MASK_PENDING_4  = 16'hCE7E;
  localparam logic [15:0] MASK_CAN_2      = 16'h000C;
  localparam logic [15:0] MASK_CAN_4      = 16'h0040;
  localparam logic [15:0] MASK_AUDIO_4    = 16'hC000;
  localparam logic [15:0] MASK_POLARITY   = 16'h0007;

  // ****************************************
  // field positions
  // ****************************************
  localparam int          BIT_EXT0        = 0;
  localparam int          BIT_EXT1        = 4;
  localparam int          BIT_EXT2        = 13;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [15:0] RST_PENDING     = 16'h0000;
  localparam logic [15:0] RST_ENABLE      = 16'h0000;
  localparam logic [15:0] RST_POLARITY    = 16'h0000;

endpackage : ifs_pkg

//--- ifs_src_model.sv
module ifs_src_model (
  input  wire logic        mclk,     // system clock
  input  wire logic        go,       // fire one pulse next cycle
  input  wire logic [79:0] vec,      // pulse pattern, register 4 on top
  input  wire logic [2:0]  pin_lvl,  // wanted external pin levels
  output logic      [79:0] src,      // source request pulses
  output logic      [2:0]  ext_pin   // external pin levels
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // sources pulse one cycle, pins follow
  // ****
  always_ff @(posedge mclk) begin
    src     <= go ? vec : 80'h0000_0000_0000_0000_0000;
    ext_pin <= pin_lvl;
  end
endmodule // ifs_src_model

//--- interrupt_flag_status_tb_top.sv
module interrupt_flag_status_tb_top;
  import ifs_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic             mclk, reset, wr, rd, go;
  logic [3:0]       addr;
  logic [15:0]      wdata, rdata, m_pol, rdata_v;
  logic [79:0]      vec, src;
  logic [95:0]      rnd;
  logic [2:0]       pins, ext_pin;
  logic [4:0][15:0] cq;
  logic [15:0]      m_pend [5];
  logic [15:0]      m_en [5];
  int               err_count, n_tests, seed, cyc, r, p;
  localparam logic [15:0] MSK [5] = '{MASK_PENDING_0, MASK_PENDING_1, MASK_PENDING_2,
                                      MASK_PENDING_3, MASK_PENDING_4};
  localparam logic [15:0] EXTM [5] = '{16'h0001, 16'h2010, 16'h0000, 16'h0000, 16'h0000};

  ifs_flags u_ifs_flags (.mclk(mclk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .src_req_0(src[15:0]), .src_req_1(src[31:16]),
    .src_req_2(src[47:32]), .src_req_3(src[63:48]), .src_req_4(src[79:64]),
    .ext_pin(ext_pin), .cpu_req_0(cq[0]), .cpu_req_1(cq[1]), .cpu_req_2(cq[2]),
    .cpu_req_3(cq[3]), .cpu_req_4(cq[4]));
  ifs_flags #(.HAS_CAN(1'b0), .HAS_AUDIO(1'b0)) u_ifs_flags_lite (.mclk(mclk), .reset(reset),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata_v), .src_req_0(src[15:0]),
    .src_req_1(src[31:16]), .src_req_2(src[47:32]), .src_req_3(src[63:48]),
    .src_req_4(src[79:64]), .ext_pin(ext_pin), .cpu_req_0(), .cpu_req_1(), .cpu_req_2(),
    .cpu_req_3(), .cpu_req_4());
  ifs_src_model u_ifs_src_model (.mclk(mclk), .go(go), .vec(vec), .pin_lvl(pins),
    .src(src), .ext_pin(ext_pin));

  // ****
  // clock, timeout, bus tasks
  // ****
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      wrap_up;
    end
  end
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    if (a < 5) m_pend[a] = d & MSK[a];
    else if (a < 10) m_en[a-5] = d & MSK[a-5];
    else if (a == ADDR_POLARITY) m_pol = d & MASK_POLARITY;
  endtask
  function automatic logic [15:0] vm(input logic [3:0] a);
    case (a)
      ADDR_PENDING_2, ADDR_ENABLE_2: vm = ~MASK_CAN_2;
      ADDR_PENDING_4, ADDR_ENABLE_4: vm = ~(MASK_CAN_4 | MASK_AUDIO_4);
      default: vm = 16'hFFFF;
    endcase
  endfunction
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 chk("rdata", e, rdata);
    chk("rdata_lite", e & vm(a), rdata_v);
  endtask
  task automatic fire(input logic [79:0] v);
    @(posedge mclk);
    go  <= 1'b1;
    vec <= v;
    @(posedge mclk);
    go <= 1'b0;
    for (int i = 0; i < 5; i++) m_pend[i] |= v[16*i +: 16] & MSK[i] & ~EXTM[i];
  endtask
  task automatic chk_all;
    repeat (3) @(posedge mclk);
    for (int i = 0; i < 5; i++) chk("cpu_req", m_pend[i] & m_en[i], cq[i]);
    for (int i = 0; i < 5; i++) rd_chk(i[3:0], m_pend[i]);
    for (int i = 0; i < 5; i++) rd_chk(i[3:0] + 4'h5, m_en[i]);
    rd_chk(ADDR_POLARITY, m_pol);
    for (int i = 11; i < 16; i++) rd_chk(i[3:0], 16'h0000);
  endtask

  // ****
  // main sequence
  // ****
  initial begin
    {reset, wr, rd, go} = 4'h8;
    {addr, wdata, vec, pins, m_pol} = '0;
    for (int i = 0; i < 5; i++) {m_pend[i], m_en[i]} = 32'h0000_0000;
    seed = 34226;
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    chk_all;
    for (r = 0; r < 12; r++) wr_reg(r[3:0], 16'hFFFF);
    chk_all;
    for (r = 0; r < 5; r++) wr_reg(r[3:0], 16'h0000);
    chk_all;
    repeat (6) begin
      rnd = {$random(seed), $random(seed), $random(seed)};
      fire(rnd[79:0]);
      wr_reg(rnd[82:80] % 5, rnd[95:80]);
      wr_reg(rnd[85:83] % 5 + 5, rnd[63:48]);
      chk_all;
    end
    @(posedge mclk);
    go  <= 1'b1;
    vec <= 80'h0000_0000_0000_0100_0000;
    @(posedge mclk);
    go    <= 1'b0;
    addr  <= ADDR_PENDING_1;
    wdata <= 16'h0000;
    wr    <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    rd_chk(ADDR_PENDING_1, 16'h0100);
    for (p = 0; p < 2; p++) begin
      @(posedge mclk);
      pins <= p ? 3'h7 : 3'h0;
      wr_reg(ADDR_POLARITY, p ? 16'h0007 : 16'h0000);
      repeat (6) @(posedge mclk);
      for (r = 0; r < 2; r++) begin
        wr_reg(ADDR_PENDING_0, 16'h0000);
        wr_reg(ADDR_PENDING_1, 16'h0000);
        @(posedge mclk);
        pins <= ~pins;
        repeat (6) @(posedge mclk);
        rd_chk(ADDR_PENDING_0, r ? 16'h0000 : 16'h0001);
        rd_chk(ADDR_PENDING_1, r ? 16'h0000 : 16'h2010);
      end
    end
    wrap_up;
  end
endmodule // interrupt_flag_status_tb_top
